//--- logic/pin_ctrl_pkg.sv
// constants for the global pin control block: register map, fields, sizes
// assumes a single 25 MHz clock domain and a plain strobe register port
package pin_ctrl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_CHAN = 17;
  localparam int NUM_GP = 2;
  localparam int TERM_W = 3;
  // register offsets
  localparam logic [3:0] OFF_REF_A = 4'h0;
  localparam logic [3:0] OFF_REF_B = 4'h1;
  localparam logic [3:0] OFF_GP = 4'h2;
  localparam logic [3:0] OFF_CHAN_SEL = 4'h3;
  localparam logic [3:0] OFF_CHAN_RX = 4'h4;
  localparam logic [3:0] OFF_CHAN_STD = 4'h5;
  localparam logic [3:0] OFF_STATUS = 4'h6;
  // field positions
  localparam int RATE_BIT = 5;
  localparam int TERM_LSB = 0;
  localparam int R120_BIT = 4;
  localparam int STD_BIT = 0;
  localparam int GP_DIR_LSB = 0;
  localparam int GP_LVL_LSB = 2;
  localparam int ST_TERM_BIT = 0;
  localparam int ST_HWEN_BIT = 1;
  localparam int ST_HWSTD_BIT = 2;
  localparam int ST_OE_BIT = 3;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_GP = 8'h00;
  localparam logic [4:0] RST_SEL = 5'h00;
  // line standard encoding: 1 = T1/J1, 0 = E1
  localparam logic STD_E1 = 1'b0;
endpackage

//--- logic/line_unit_global_pin_control.sv
// global pin-driven control of the line interface: strap synchronisers,
// receive termination gating, line driver enable, standard selection, gpio
// assumes strap and gpio pins are asynchronous to CLK; one register port
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps

// Function
// [R1] software sets reference A rate bit to match the clock on input A
// [R2] software sets reference B rate bit to match the clock on input B
// [R3] differential mode, termination pin low: all receivers high impedance
// [R4] termination pin high: per-channel term field and 120 ohm bit apply
// [R5] output enable pin low forces every line driver to high impedance
// [R6] output enable affects only line drivers, internal logic runs on
// [R7] hardware enable open: standard from hardware pin, else per channel
// [R8] hardware pin low means E1, open means T1/J1; ignored if disabled
// [R9] each general purpose pin direction set by its own direction bit
// [R10] input pins report their synchronised level in the level field
// [R11] output pins drive the level bit written by software
// [R12] strap and gpio inputs pass a two-stage synchroniser first
module line_unit_global_pin_control #(
  parameter int NCH = pin_ctrl_pkg::NUM_CHAN
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // register port
  input wire logic [pin_ctrl_pkg::ADDR_W-1:0] ADDR,
  input wire logic [pin_ctrl_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [pin_ctrl_pkg::DATA_W-1:0] RDATA,
  // strap pins (open reads as high)
  input wire logic RX_TERMINATION_CTRL_PIN,
  input wire logic LINE_OE_PIN,
  input wire logic HW_STANDARD_SEL_ENABLE,
  input wire logic HW_STANDARD_SEL_PIN,
  input wire logic RX_DIFF_MODE,
  // general purpose pins
  input wire logic [pin_ctrl_pkg::NUM_GP-1:0] GP_IN,
  output logic [pin_ctrl_pkg::NUM_GP-1:0] GP_OUT,
  output logic [pin_ctrl_pkg::NUM_GP-1:0] GP_OE,
  // reference input rate selects, 1 = E1
  output logic REF_IN_A_RATE_SEL,
  output logic REF_IN_B_RATE_SEL,
  // per-channel effective configuration
  output logic [NCH-1:0] RX_HIGHZ,
  output logic [NCH*pin_ctrl_pkg::TERM_W-1:0] RX_TERM,
  output logic [NCH-1:0] RX_120OHM,
  output logic [NCH-1:0] LINE_STD,
  output logic [NCH-1:0] TX_DRIVER_EN
);
  import pin_ctrl_pkg::*;

  // positions of the strap bits inside the synchroniser word
  localparam int SY_TERM = 0;
  localparam int SY_OE = 1;
  localparam int SY_HWEN = 2;
  localparam int SY_HWSTD = 3;
  localparam int SY_DIFF = 4;
  localparam int SY_GP = 5;
  localparam int SYNC_W = SY_GP + NUM_GP;
  // width of the channel select field
  localparam int SEL_W = 5;

  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] sync_q;
  logic term_s, oe_s, hwen_s, hwstd_s, diff_s;
  logic [NUM_GP-1:0] gp_s;
  logic [7:0] ref_a_q, ref_b_q, gp_q;
  logic [SEL_W-1:0] chan_sel_q;
  logic [TERM_W-1:0] term_q [NCH];
  logic [NCH-1:0] r120_q;
  logic [NCH-1:0] std_q;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] gp_rd_d;
  logic [DATA_W-1:0] status_d;
  logic [SEL_W-1:0] sel;
  logic sel_ok;

  // a channel index reaches storage only while it names a real channel;
  // larger select values are kept so software can read them back
  function automatic logic chan_valid(input logic [SEL_W-1:0] idx);
    return 32'(idx) < NCH;
  endfunction

  // level of one gpio as software reads it: latch for outputs, pin else
  function automatic logic gp_level(input logic dir, input logic latch,
                                    input logic pin);
    return dir ? latch : pin;
  endfunction

  // first stage feeds only the second stage
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {GP_IN, RX_DIFF_MODE, HW_STANDARD_SEL_PIN,
                 HW_STANDARD_SEL_ENABLE, LINE_OE_PIN,
                 RX_TERMINATION_CTRL_PIN}; // R12
      sync_q <= meta_q; // R12
    end
  end

  // named views of the second synchroniser stage; a strap change reaches
  // the outputs two edges after it is sampled
  assign term_s = sync_q[SY_TERM];
  assign oe_s = sync_q[SY_OE];
  assign hwen_s = sync_q[SY_HWEN];
  assign hwstd_s = sync_q[SY_HWSTD];
  assign diff_s = sync_q[SY_DIFF];
  assign gp_s = sync_q[SY_GP +: NUM_GP];

  // channel access is refused while the select names no channel
  assign sel = chan_sel_q;
  assign sel_ok = chan_valid(sel);

  // gpio byte as read: level bits of input pins show the pin
  always_comb begin
    gp_rd_d = gp_q;
    for (int g = 0; g < NUM_GP; g++) begin
      gp_rd_d[GP_LVL_LSB + g] = gp_level(gp_q[GP_DIR_LSB + g],
          gp_q[GP_LVL_LSB + g], gp_s[g]); // R10
    end
  end

  // status byte: synchronised strap levels as the block sees them
  always_comb begin
    status_d = '0;
    status_d[ST_TERM_BIT] = term_s;
    status_d[ST_HWEN_BIT] = hwen_s;
    status_d[ST_HWSTD_BIT] = hwstd_s;
    status_d[ST_OE_BIT] = oe_s; // R12
  end

  // reference rate registers; only the rate bit has a function
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_a_q <= RST_BYTE;
    end else if (WR && ADDR == OFF_REF_A) begin
      ref_a_q <= WDATA; // R1
    end
  end

  // reference B register, same layout as reference A
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ref_b_q <= RST_BYTE;
    end else if (WR && ADDR == OFF_REF_B) begin
      ref_b_q <= WDATA; // R2
    end
  end

  // gpio direction and level byte
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      gp_q <= RST_GP;
    end else if (WR && ADDR == OFF_GP) begin
      gp_q <= WDATA; // R9 R11
    end
  end

  // channel select; out-of-range values are kept and block channel access
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      chan_sel_q <= RST_SEL;
    end else if (WR && ADDR == OFF_CHAN_SEL) begin
      chan_sel_q <= WDATA[SEL_W-1:0];
    end
  end

  // per-channel receive settings, reached through the channel select
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < NCH; i++) begin
        term_q[i] <= '0;
      end
      r120_q <= '0;
    end else if (WR && sel_ok && ADDR == OFF_CHAN_RX) begin
      term_q[sel] <= WDATA[TERM_LSB +: TERM_W]; // R4
      r120_q[sel] <= WDATA[R120_BIT]; // R4
    end
  end

  // per-channel line standard bit
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      std_q <= '0;
    end else if (WR && sel_ok && ADDR == OFF_CHAN_STD) begin
      std_q[sel] <= WDATA[STD_BIT]; // R7
    end
  end

  // read mux; level bits of input pins show the pin, not the register
  always_comb begin
    rdata_d = '0;
    case (ADDR)
      OFF_REF_A: rdata_d = ref_a_q;
      OFF_REF_B: rdata_d = ref_b_q;
      OFF_GP: rdata_d = gp_rd_d; // R10
      OFF_CHAN_SEL: rdata_d = DATA_W'(chan_sel_q);
      OFF_CHAN_RX: begin
        if (sel_ok) begin
          rdata_d[TERM_LSB +: TERM_W] = term_q[sel];
          rdata_d[R120_BIT] = r120_q[sel];
        end
      end
      OFF_CHAN_STD: begin
        if (sel_ok) begin
          rdata_d[STD_BIT] = std_q[sel];
        end
      end
      OFF_STATUS: rdata_d = status_d;
      default: rdata_d = '0;
    endcase
  end

  // read data stand in the cycle after each cycle with RD high and read zero otherwise
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? rdata_d : '0;
    end
  end

  // gpio enable, registered so a pin turns around one edge after the write
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      GP_OE <= '0;
    end else begin
      GP_OE <= gp_q[GP_DIR_LSB +: NUM_GP]; // R9
    end
  end

  // gpio drive level; meaningful on the wire only while enabled
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      GP_OUT <= '0;
    end else begin
      GP_OUT <= gp_q[GP_LVL_LSB +: NUM_GP]; // R11
    end
  end

  // reference rate selects follow the rate bit of each reference register
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      REF_IN_A_RATE_SEL <= 1'b0;
      REF_IN_B_RATE_SEL <= 1'b0;
    end else begin
      REF_IN_A_RATE_SEL <= ref_a_q[RATE_BIT]; // R1
      REF_IN_B_RATE_SEL <= ref_b_q[RATE_BIT]; // R2
    end
  end

  // receive termination; single-ended mode leaves the pin without effect
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RX_HIGHZ <= '1;
      RX_TERM <= '0;
      RX_120OHM <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (diff_s && !term_s) begin
          RX_HIGHZ[c] <= 1'b1; // R3
          RX_TERM[c*TERM_W +: TERM_W] <= '0; // R3
          RX_120OHM[c] <= 1'b0; // R3
        end else begin
          RX_HIGHZ[c] <= 1'b0; // R4
          RX_TERM[c*TERM_W +: TERM_W] <= term_q[c]; // R4
          RX_120OHM[c] <= r120_q[c]; // R4
        end
      end
    end
  end

  // line standard: hardware pin low = E1, open (high) = T1/J1
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      LINE_STD <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (hwen_s) begin
          LINE_STD[c] <= hwstd_s ? ~STD_E1 : STD_E1; // R8
        end else begin
          LINE_STD[c] <= std_q[c]; // R7
        end
      end
    end
  end

  // the enable gates only the drivers; nothing else in a channel sees it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      TX_DRIVER_EN <= '0;
    end else begin
      TX_DRIVER_EN <= {NCH{oe_s}}; // R5 R6
    end
  end
endmodule // line_unit_global_pin_control

//--- tb/pin_ctrl_asserts.sv
// checker: pin control outputs tied to their causes at the ports
// assumes it is bound to line_unit_global_pin_control, one clock
`timescale 1ns/100ps
module pin_ctrl_asserts #(parameter int NCH = 17) (
  // clock, reset, register port
  input wire logic CLK, RESETN, WR, RD,
  input wire logic [pin_ctrl_pkg::ADDR_W-1:0] ADDR,
  input wire logic [pin_ctrl_pkg::DATA_W-1:0] WDATA, RDATA,
  // strap pins
  input wire logic RX_TERMINATION_CTRL_PIN, LINE_OE_PIN, RX_DIFF_MODE,
  input wire logic HW_STANDARD_SEL_ENABLE, HW_STANDARD_SEL_PIN,
  // derived outputs
  input wire logic [pin_ctrl_pkg::NUM_GP-1:0] GP_OUT, GP_OE,
  input wire logic [NCH-1:0] RX_HIGHZ, LINE_STD, TX_DRIVER_EN
);
  import pin_ctrl_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence gp_wr;
    WR && ADDR == OFF_GP;
  endsequence
  // pins need three edges: two synchroniser stages and the output flop
  chk_oe_on:
    assert property (LINE_OE_PIN [*3] |=> &TX_DRIVER_EN) else $error("oe on");
  chk_oe_off:
    assert property (!LINE_OE_PIN [*3] |=> TX_DRIVER_EN == '0)
    else $error("oe off");
  chk_term_off:
    assert property ((RX_DIFF_MODE && !RX_TERMINATION_CTRL_PIN) [*3]
      |=> &RX_HIGHZ) else $error("rx not high z");
  chk_term_on:
    assert property ((RX_DIFF_MODE && RX_TERMINATION_CTRL_PIN) [*3]
      |=> RX_HIGHZ == '0) else $error("rx high z");
  chk_hw_e1:
    assert property ((HW_STANDARD_SEL_ENABLE && !HW_STANDARD_SEL_PIN) [*3]
      |=> LINE_STD == '0) else $error("hw e1");
  chk_hw_t1:
    assert property ((HW_STANDARD_SEL_ENABLE && HW_STANDARD_SEL_PIN) [*3]
      |=> &LINE_STD) else $error("hw t1");
  chk_rdata_idle:
    assert property (!RD |=> RDATA == '0) else $error("rdata not idle");
  property gp_dir;
    gp_wr |-> ##2 GP_OE == $past(WDATA[1:0], 2);
  endproperty
  property gp_drv;
    gp_wr |-> ##2 (GP_OUT & GP_OE) == $past(WDATA[3:2] & WDATA[1:0], 2);
  endproperty
  chk_gp_dir:
    assert property (gp_dir) else $error("gpio direction");
  chk_gp_drive:
    assert property (gp_drv) else $error("gpio drive");
endmodule // pin_ctrl_asserts

bind line_unit_global_pin_control pin_ctrl_asserts #(.NCH(NCH)) chk_i (.*);

//--- tb/strap_board_model.sv
// board side of the gpio pins: resolves the shared wire level
// assumes the board always drives its own level when the block does not
`timescale 1ns/100ps
module strap_board_model (
  input wire logic [1:0] gp_oe,
  input wire logic [1:0] gp_out,
  input wire logic [1:0] gp_ext,
  output logic [1:0] gp_pin
);
  always_comb begin
    for (int i = 0; i < 2; i++) gp_pin[i] = gp_oe[i] ? gp_out[i] : gp_ext[i];
  end
endmodule // strap_board_model

//--- tb/test_line_unit_global_pin_control.sv
// self-checking bench for the global pin control block
// assumes the checker is bound and the board model closes the gpio wire
`timescale 1ns/100ps
module test_line_unit_global_pin_control;
  import pin_ctrl_pkg::*;
  logic CLK = 0, RESETN = 0, WR = 0, RD = 0, LINE_OE_PIN = 0;
  logic RX_TERMINATION_CTRL_PIN = 0, RX_DIFF_MODE = 0;
  logic HW_STANDARD_SEL_ENABLE = 0, HW_STANDARD_SEL_PIN = 0;
  logic [3:0] ADDR = '0;
  logic [7:0] WDATA = '0, RDATA;
  logic [1:0] GP_IN, GP_OUT, GP_OE, gp_ext = '0;
  logic REF_IN_A_RATE_SEL, REF_IN_B_RATE_SEL;
  logic [16:0] RX_HIGHZ, RX_120OHM, LINE_STD, TX_DRIVER_EN, m_r120, m_std;
  logic [50:0] RX_TERM, m_term;
  logic [15:0] lfsr = 16'h07ce;
  int err_total = 0, n_checks = 0;
  line_unit_global_pin_control line_unit_global_pin_control_i (.*);
  strap_board_model strap_board_model_i (.gp_oe(GP_OE), .gp_out(GP_OUT),
    .gp_ext(gp_ext), .gp_pin(GP_IN));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic cmp(logic [50:0] got, logic [50:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge CLK);
    WR <= 1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 0;
  endtask
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge CLK);
    RD <= 1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 0;
    #1 cmp(RDATA, e);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    forever #20 CLK = ~CLK;
  end
  initial begin
    logic [15:0] r;
    logic hz;
    repeat (4) @(posedge CLK);
    cmp({RX_HIGHZ, TX_DRIVER_EN, LINE_STD}, {17'h1_ffff, 34'h0});
    RESETN <= 1;
    wr(OFF_REF_A, 8'h20);
    wr(OFF_REF_B, 8'h00);
    rd(OFF_REF_A, 8'h20);
    cmp({REF_IN_A_RATE_SEL, REF_IN_B_RATE_SEL}, 2'b10);
    rd(4'hf, 8'h00);
    wr(OFF_CHAN_SEL, 8'h11);
    rd(OFF_CHAN_RX, 8'h00);
    for (int c = 0; c < 17; c++) begin
      r = rnd();
      m_term[3*c +: 3] = r[2:0];
      m_r120[c] = r[4];
      m_std[c] = r[8];
      wr(OFF_CHAN_SEL, c[7:0]);
      wr(OFF_CHAN_RX, {3'h0, r[4], 1'b0, r[2:0]});
      wr(OFF_CHAN_STD, {7'h0, r[8]});
    end
    // every combination of the four other straps; the oe level is scrambled against them
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      @(posedge CLK);
      {RX_DIFF_MODE, RX_TERMINATION_CTRL_PIN} <= i[3:2];
      {HW_STANDARD_SEL_ENABLE, HW_STANDARD_SEL_PIN} <= i[1:0];
      LINE_OE_PIN <= i[0] ^ i[3];
      gp_ext <= r[6:5];
      wr(OFF_GP, {4'h0, r[10:7]});
      repeat (4) @(posedge CLK);
      #1 hz = i[3] && !i[2];
      cmp(RX_HIGHZ, hz ? 17'h1_ffff : 17'h0);
      if (!hz) cmp({RX_TERM, RX_120OHM}, {m_term, m_r120});
      cmp(TX_DRIVER_EN, (i[0] ^ i[3]) ? 17'h1_ffff : 17'h0);
      cmp(LINE_STD, i[1] ? {17{i[0]}} : m_std);
      cmp({GP_OE, GP_OUT & GP_OE}, {r[8:7], r[10:9] & r[8:7]});
      rd(OFF_GP, {4'h0, r[10:9] & r[8:7] | r[6:5] & ~r[8:7], r[8:7]});
      rd(OFF_STATUS, {4'h0, i[0] ^ i[3], i[0], i[1], i[2]});
    end
    tally_and_finish();
  end
endmodule // test_line_unit_global_pin_control
